// *** verilog/pwmg_top.sv ***
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module pwmg_top
(
   input  wire logic                        clk_sys_i,
   input  wire logic                        reset_i,
   input  wire logic                        ce_i,
   input  wire logic                        psel_i,
   input  wire logic                        penable_i,
   input  wire logic                        pwrite_i,
   input  wire logic [pwmg_pkg::ADDR_W-1:0] paddr_i,
   input  wire logic [pwmg_pkg::DATA_W-1:0] pwdata_i,
   output logic      [pwmg_pkg::DATA_W-1:0] prdata_o,
   output logic                             pready_o,
   output logic                             pslverr_o,
   input  wire logic                        timer_pwm_source_i,
   input  wire logic [1:0]                  chan_raw_compare_i,
   input  wire logic [1:0]                  cal_compare_i,
   output logic                             upper_drive_out_o,
   output logic                             lower_drive_out_o,
   output logic      [1:0]                  oc_irq_o,
   output logic      [1:0][7:0]             oc_dac_code_o,
   output logic      [1:0][2:0]             oc_gain_sel_o,
   output logic      [1:0]                  oc_hyst_en_o,
   output logic      [1:0][3:0]             oc_switch_o,
   output logic      [1:0]                  oc_power_en_o,
   output logic      [1:0]                  amp_cancel_mode_o,
   output logic      [1:0]                  amp_cancel_ref_sel_o,
   output logic      [1:0][5:0]             amp_trim_o,
   output logic      [1:0]                  comp_cancel_mode_o,
   output logic      [1:0]                  comp_cancel_ref_sel_o,
   output logic      [1:0][4:0]             comp_trim_o
);
   import pwmg_pkg::*;

   typedef struct packed {
      logic [7:0]      dt;
      logic [7:0]      mode;
      logic [1:0][6:0] cfg;
      logic [1:0][7:0] dac;
      logic [1:0][7:0] amp;
      logic [1:0][6:0] comp;
      logic [1:0]      pol;
      logic [1:0]      fdiv;
      logic            rvalid;
      logic [7:0]      rdata;
      logic            up;
      logic            lo;
   } pwmg_top_st_t;

   localparam pwmg_top_st_t ST_RST = '{
      dt:     RST_DT,
      mode:   RST_MODE,
      cfg:    {RST_CFG, RST_CFG},
      dac:    {RST_DAC, RST_DAC},
      amp:    {RST_AMP, RST_AMP},
      comp:   {RST_COMP, RST_COMP},
      pol:    RST_POL,
      fdiv:   2'h0,
      rvalid: 1'b0,
      rdata:  8'h00,
      up:     INACT_UP,
      lo:     INACT_LO
   };

   // Word index of a byte address, or the unmapped marker
   function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
      logic [3:0] r;
      r = IDX_NONE;
      if (a[1:0] == 2'h0 && a[ADDR_W-1:6] == '0 && a[5:2] <= IDX_PIN)
         r = a[5:2];
      return r;
   endfunction

   // Word index of one register of a channel group
   function automatic logic [3:0] chan_index(input int c, input logic [1:0] k);
      return IDX_CH0 + 4'(c) * CH_STRIDE + {2'h0, k};
   endfunction

   // Mode field of a channel
   function automatic pwmg_mode_t chan_mode(input logic [7:0] m, input int c);
      return pwmg_mode_t'((c == 0) ? m[MODE_LSB0 +: 2] : m[MODE_LSB1 +: 2]);
   endfunction

   // Analog switch pattern S3..S0 for a mode
   function automatic logic [3:0] sw_pattern(input pwmg_mode_t md);
      logic [3:0] p;
      unique case (md)
         PWMG_MODE_OFF:    p = 4'hA;
         PWMG_MODE_NONINV: p = 4'h9;
         PWMG_MODE_INV:    p = 4'h6;
         PWMG_MODE_ZERO:   p = 4'hA;
      endcase
      return p;
   endfunction

   // Dead time in system cycles: (length + 1) dead-time clock periods
   function automatic logic [DT_CNT_W-1:0] dt_cycles(input logic [1:0] psc,
                                                     input logic [2:0] len);
      logic [DT_CNT_W-1:0] t;
      t = {4'h0, len} + DT_CNT_W'(1);
      return t << psc;
   endfunction

   pwmg_top_st_t        s_q;
   pwmg_top_st_t        s_d;
   logic [3:0]          idx;
   logic                access;
   logic                wr_en;
   logic                deadtime_enable;
   logic                flt_tick;
   logic                dly_lo;
   logic                dly_up;
   logic                complementary_high_wave;
   logic                complementary_low_wave;
   logic                force_up;
   logic                force_lo;
   logic [DT_CNT_W-1:0] dt_len_cyc;
   logic [1:0]          filt;
   logic [1:0]          evt;
   logic [1:0]          cal_active;
   pwmg_mode_t          md [2];
   logic [7:0]          rd;

   // APB decode; ready waits one enabled cycle so read data is captured
   assign idx       = reg_index(paddr_i);
   assign access    = psel_i && penable_i;
   assign pready_o  = ce_i && s_q.rvalid;
   assign pslverr_o = access && idx == IDX_NONE;
   assign wr_en     = access && pready_o && pwrite_i && idx != IDX_NONE;
   assign prdata_o  = {24'h0, s_q.rdata};
   assign flt_tick  = s_q.fdiv == FLT_DIV_LAST;

   assign dt_len_cyc = dt_cycles(s_q.dt[DT_PSC_LSB +: 2],
                                 s_q.dt[DT_LEN_LSB +: 3]);
   assign deadtime_enable       = s_q.dt[DT_EN_BIT];

   // Lower wave delays source rise, upper wave delays source fall
   pwmg_rise_delay u_dly_lo
   (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .ce_i      (ce_i),
      .src_i     (timer_pwm_source_i),
      .cycles_i  (dt_len_cyc),
      .dly_o     (dly_lo)
   );

   pwmg_rise_delay u_dly_up
   (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .ce_i      (ce_i),
      .src_i     (!timer_pwm_source_i),
      .cycles_i  (dt_len_cyc),
      .dly_o     (dly_up)
   );

   // bypass when dead time is off
   assign complementary_high_wave = deadtime_enable ? !dly_up : timer_pwm_source_i;
   assign complementary_low_wave = deadtime_enable ? dly_lo : timer_pwm_source_i;

   // Per-channel filter and analog control fields
   for (genvar c = 0; c < 2; c++)
   begin : g_chan
      pwmg_flt_if u_if ();

      assign md[c]            = chan_mode(s_q.mode, c);
      assign u_if.raw         = chan_raw_compare_i[c];
      assign u_if.sel         = s_q.cfg[c][CFG_FLT_LSB +: 3];
      assign u_if.enable      = md[c] != PWMG_MODE_OFF;
      assign u_if.tick        = flt_tick;
      assign filt[c]          = u_if.filtered;
      assign evt[c]           = u_if.event_p;
      assign oc_dac_code_o[c] = s_q.dac[c];
      assign oc_gain_sel_o[c] =
         (s_q.cfg[c][CFG_GAIN_LSB +: 3] > GAIN_MAX) ? GAIN_MAX :
         s_q.cfg[c][CFG_GAIN_LSB +: 3];
      assign oc_hyst_en_o[c]  = s_q.cfg[c][CFG_HYST_BIT];
      assign oc_switch_o[c]   = sw_pattern(md[c]);
      assign oc_power_en_o[c] = md[c] != PWMG_MODE_OFF;
      assign amp_cancel_mode_o[c] = s_q.amp[c][AMP_CANCEL_BIT]
                                    && md[c] == PWMG_MODE_ZERO;
      assign comp_cancel_mode_o[c] = s_q.comp[c][COMP_CANCEL_BIT]
                                     && md[c] == PWMG_MODE_ZERO;
      assign amp_cancel_ref_sel_o[c]  = s_q.amp[c][AMP_REF_BIT];
      assign comp_cancel_ref_sel_o[c] = s_q.comp[c][COMP_REF_BIT];
      assign amp_trim_o[c]    = s_q.amp[c][5:0];
      assign comp_trim_o[c]   = s_q.comp[c][4:0];
      assign cal_active[c]    = amp_cancel_mode_o[c] || comp_cancel_mode_o[c];

      pwmg_trip_filter u_filter
      (
         .clk_sys_i (clk_sys_i),
         .reset_i   (reset_i),
         .ce_i      (ce_i),
         .flt       (u_if.filt)
      );
   end

   assign oc_irq_o = evt;

   assign force_up = (filt[0] && s_q.mode[EN_UP_BIT0])
                     || (filt[1] && s_q.mode[EN_UP_BIT1]);
   assign force_lo = (filt[0] && s_q.mode[EN_LO_BIT0])
                     || (filt[1] && s_q.mode[EN_LO_BIT1]);

   // Next state: register writes, read capture and drive outputs
   always_comb
   begin
      s_d        = s_q;
      rd         = 8'h00;
      s_d.fdiv   = s_q.fdiv + 2'h1;
      s_d.rvalid = psel_i && !(penable_i && pready_o);
      if (wr_en)
      begin
         if (idx == IDX_DT)
            s_d.dt = pwdata_i[7:0] & DT_WMASK;
         if (idx == IDX_MODE)
            s_d.mode = pwdata_i[7:0];
         if (idx == IDX_PIN)
            s_d.pol = pwdata_i[1:0];
         for (int c = 0; c < 2; c++)
         begin
            if (idx == chan_index(c, REG_CFG))
               s_d.cfg[c] = pwdata_i[6:0];
            if (idx == chan_index(c, REG_DAC))
               s_d.dac[c] = pwdata_i[7:0];
            if (idx == chan_index(c, REG_AMP))
               s_d.amp[c] = pwdata_i[7:0];
            if (idx == chan_index(c, REG_COMP))
               s_d.comp[c] = pwdata_i[6:0];
         end
      end
      // Read mux; status bits are sampled live each cycle
      if (idx == IDX_DT)
         rd = s_q.dt;
      if (idx == IDX_MODE)
         rd = s_q.mode;
      if (idx == IDX_PIN)
         rd = {6'h00, s_q.pol};
      for (int c = 0; c < 2; c++)
      begin
         if (idx == chan_index(c, REG_CFG))
            rd = {filt[c], s_q.cfg[c]};
         if (idx == chan_index(c, REG_DAC))
            rd = s_q.dac[c];
         if (idx == chan_index(c, REG_AMP))
            rd = s_q.amp[c];
         // calibration compare only in cancel mode
         if (idx == chan_index(c, REG_COMP))
            rd = {cal_compare_i[c] && cal_active[c], s_q.comp[c]};
      end
      s_d.rdata = rd;
      s_d.up = (force_up ? INACT_UP : complementary_high_wave) ^ s_q.pol[POL_UP_BIT];
      s_d.lo = (force_lo ? INACT_LO : complementary_low_wave) ^ s_q.pol[POL_LO_BIT];
   end

   // State register; clock enable freezes everything
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         s_q <= ST_RST;
      else if (ce_i)
         s_q <= s_d;
   end

   assign upper_drive_out_o = s_q.up;
   assign lower_drive_out_o = s_q.lo;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   sequence dt_read_s;
      ce_i && psel_i && !pwrite_i && idx == IDX_DT;
   endsequence
   sequence cfg0_read_s;
      ce_i && psel_i && !pwrite_i && idx == chan_index(0, REG_CFG);
   endsequence

   dt_bits_zero_a: assert property (
      dt_read_s |=> prdata_o[6:5] == 2'h0)
      else $error("dead-time bits 6:5 did not read zero");
   status_read_a: assert property (
      cfg0_read_s |=> prdata_o[7] == $past(filt[0]))
      else $error("status bit does not show filtered result");
   trip_upper_a: assert property (
      (ce_i && force_up) |=> upper_drive_out_o == !$past(s_q.pol[POL_UP_BIT]))
      else $error("upper output not forced inactive");
   trip_lower_a: assert property (
      (ce_i && force_lo) |=> lower_drive_out_o == $past(s_q.pol[POL_LO_BIT]))
      else $error("lower output not forced inactive");
   release_follow_a: assert property (
      (ce_i && !force_up && !force_lo) |=>
      upper_drive_out_o == ($past(complementary_high_wave) ^ $past(s_q.pol[POL_UP_BIT]))
      && lower_drive_out_o == ($past(complementary_low_wave) ^ $past(s_q.pol[POL_LO_BIT])))
      else $error("outputs do not follow PWM after release");
   irq_on_rise_a: assert property (
      $rose(filt[1]) |-> oc_irq_o[1] ##1 (!oc_irq_o[1] || !ce_i || filt[1]))
      else $error("channel request missing on trip");
   bypass_follow_a: assert property (
      (ce_i && !deadtime_enable && !force_up && !force_lo) |=>
      upper_drive_out_o == ($past(timer_pwm_source_i)
                            ^ $past(s_q.pol[POL_UP_BIT]))
      && lower_drive_out_o == ($past(timer_pwm_source_i)
                               ^ $past(s_q.pol[POL_LO_BIT])))
      else $error("waves differ from source with dead time off");
   amp_cancel_a: assert property (
      amp_cancel_mode_o[0] |-> s_q.mode[MODE_LSB0 +: 2] == 2'h3
      && s_q.amp[0][AMP_CANCEL_BIT])
      else $error("amplifier cancel outside mode 11");
   comp_cancel_a: assert property (
      comp_cancel_mode_o[1] |-> s_q.mode[MODE_LSB1 +: 2] == 2'h3
      && s_q.comp[1][COMP_CANCEL_BIT])
      else $error("comparator cancel outside mode 11");
   ch1_force_a: assert property (
      (ce_i && filt[1] && s_q.mode[EN_LO_BIT1]) |=>
      lower_drive_out_o == $past(s_q.pol[POL_LO_BIT]))
      else $error("channel 1 trip not forcing lower output");
   no_overlap_a: assert property (
      (deadtime_enable && dt_len_cyc > DT_CNT_W'(1)) |-> !(complementary_low_wave && !complementary_high_wave))
      else $error("both transistors on during dead time");
endmodule

// *** common/pwmg_pkg.sv ***
package pwmg_pkg;
   // Bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Register word indices; byte address is four times the index
   localparam logic [3:0] IDX_DT    = 4'h0;
   localparam logic [3:0] IDX_MODE  = 4'h1;
   localparam logic [3:0] IDX_CH0   = 4'h2;
   localparam logic [3:0] CH_STRIDE = 4'h4;
   localparam logic [3:0] IDX_PIN   = 4'hA;
   localparam logic [3:0] IDX_NONE  = 4'hF;
   // Word order inside one channel group
   localparam logic [1:0] REG_CFG  = 2'h0;
   localparam logic [1:0] REG_DAC  = 2'h1;
   localparam logic [1:0] REG_AMP  = 2'h2;
   localparam logic [1:0] REG_COMP = 2'h3;

   // Values after reset
   localparam logic [7:0] RST_DT   = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [6:0] RST_CFG  = 7'h00;
   localparam logic [7:0] RST_DAC  = 8'h00;
   localparam logic [7:0] RST_AMP  = 8'h20;
   localparam logic [6:0] RST_COMP = 7'h10;
   localparam logic [1:0] RST_POL  = 2'h0;

   // Field positions
   localparam int unsigned DT_EN_BIT       = 7;
   localparam int unsigned DT_PSC_LSB      = 3;
   localparam int unsigned DT_LEN_LSB      = 0;
   localparam logic [7:0]  DT_WMASK        = 8'h9F;
   localparam int unsigned MODE_LSB0       = 6;
   localparam int unsigned MODE_LSB1       = 4;
   localparam int unsigned EN_UP_BIT0      = 0;
   localparam int unsigned EN_LO_BIT0      = 1;
   localparam int unsigned EN_UP_BIT1      = 2;
   localparam int unsigned EN_LO_BIT1      = 3;
   localparam int unsigned CFG_HYST_BIT    = 6;
   localparam int unsigned CFG_GAIN_LSB    = 3;
   localparam int unsigned CFG_FLT_LSB     = 0;
   localparam int unsigned AMP_CANCEL_BIT  = 7;
   localparam int unsigned AMP_REF_BIT     = 6;
   localparam int unsigned COMP_CANCEL_BIT = 6;
   localparam int unsigned COMP_REF_BIT    = 5;
   localparam int unsigned POL_LO_BIT      = 0;
   localparam int unsigned POL_UP_BIT      = 1;

   // Channel operating modes
   typedef enum logic [1:0] {
      PWMG_MODE_OFF    = 2'h0,
      PWMG_MODE_NONINV = 2'h1,
      PWMG_MODE_INV    = 2'h2,
      PWMG_MODE_ZERO   = 2'h3
   } pwmg_mode_t;

   // Highest distinct gain code; codes above it give the same gain
   localparam logic [2:0] GAIN_MAX = 3'h5;
   // Forced levels before polarity is applied
   localparam logic INACT_UP = 1'b1;
   localparam logic INACT_LO = 1'b0;
   // Filter clock is the system clock divided by four
   localparam logic [1:0]  FLT_DIV_LAST = 2'h3;
   localparam int unsigned DT_CNT_W     = 7;
   localparam int unsigned FLT_CNT_W    = 7;
endpackage

// *** common/pwmg_flt_if.sv ***
`timescale 1ns/1ns
interface pwmg_flt_if;
   logic       raw;
   logic [2:0] sel;
   logic       enable;
   logic       tick;
   logic       filtered;
   logic       event_p;
   modport ctrl (output raw, sel, enable, tick, input filtered, event_p);
   modport filt (input raw, sel, enable, tick, output filtered, event_p);
endinterface

// *** verilog/pwmg_trip_filter.sv ***
`timescale 1ns/1ns
module pwmg_trip_filter
(
   input  wire logic clk_sys_i,
   input  wire logic reset_i,
   input  wire logic ce_i,
   pwmg_flt_if.filt  flt
);
   import pwmg_pkg::*;

   typedef struct packed {
      logic                 filt;
      logic                 evt;
      logic [FLT_CNT_W-1:0] cnt;
   } pwmg_flt_st_t;

   pwmg_flt_st_t         s_q;
   pwmg_flt_st_t         s_d;
   logic [FLT_CNT_W-1:0] hold;

   // Count end is two to the code minus one; one more tick flips the result
   assign hold = FLT_CNT_W'((8'h01 << flt.sel) - 8'h01);

   // While enabled, result changes only after the raw level held for the whole count
   always_comb
   begin
      s_d     = s_q;
      s_d.evt = 1'b0;
      if (!flt.enable)
      begin
         s_d.filt = 1'b0;
         s_d.cnt  = '0;
      end
      else if (flt.raw == s_q.filt)
         s_d.cnt = '0;
      else if (flt.sel == 3'h0)
      begin
         s_d.filt = flt.raw;
         s_d.evt  = flt.raw;
      end
      else if (flt.tick)
      begin
         if (s_q.cnt == hold)
         begin
            s_d.filt = flt.raw;
            s_d.evt  = flt.raw;
            s_d.cnt  = '0;
         end
         else
            s_d.cnt = s_q.cnt + FLT_CNT_W'(1);
      end
   end

   // State register
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         s_q <= '0;
      else if (ce_i)
         s_q <= s_d;
   end

   assign flt.filtered = s_q.filt;
   assign flt.event_p  = s_q.evt;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   flt_hold_a: assert property (
      (ce_i && flt.enable && flt.sel != 3'h0 && flt.raw != s_q.filt
       && !(flt.tick && s_q.cnt == hold))
      |=> s_q.filt == $past(s_q.filt))
      else $error("filtered result changed before hold time");
endmodule

// *** verilog/pwmg_rise_delay.sv ***
`timescale 1ns/1ns
module pwmg_rise_delay
(
   input  wire logic                          clk_sys_i,
   input  wire logic                          reset_i,
   input  wire logic                          ce_i,
   input  wire logic                          src_i,
   input  wire logic [pwmg_pkg::DT_CNT_W-1:0] cycles_i,
   output logic                               dly_o
);
   import pwmg_pkg::*;

   typedef struct packed {
      logic                q;
      logic [DT_CNT_W-1:0] cnt;
   } pwmg_dly_st_t;

   pwmg_dly_st_t s_q;
   pwmg_dly_st_t s_d;

   // Falls at once with the input, rises only after the dead time
   always_comb
   begin
      s_d = s_q;
      if (!src_i)
      begin
         s_d.q   = 1'b0;
         s_d.cnt = '0;
      end
      else if (!s_q.q)
      begin
         if (s_q.cnt == cycles_i - DT_CNT_W'(1))
            s_d.q = 1'b1;
         else
            s_d.cnt = s_q.cnt + DT_CNT_W'(1);
      end
   end

   // State register
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         s_q <= '0;
      else if (ce_i)
         s_q <= s_d;
   end

   assign dly_o = s_q.q;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   dly_length_a: assert property (
      $rose(s_q.q) |-> $past(s_q.cnt) == $past(cycles_i) - DT_CNT_W'(1))
      else $error("dead time ended at wrong count");
   dly_drop_a: assert property (
      (ce_i && !src_i) |=> !dly_o)
      else $error("delayed output did not fall with input");
endmodule

// *** testbench/pwmg_mos_pair.sv ***
`timescale 1ns/1ns
// Behavioural power transistor pair seen from the two drive pins
module pwmg_mos_pair
(
   input  wire logic upper_gate_i,
   input  wire logic lower_gate_i,
   output logic      upper_on_o,
   output logic      lower_on_o
);
   // Upper device is P-type, so it conducts on a low gate; no delay modelled
   assign upper_on_o = !upper_gate_i;
   assign lower_on_o = lower_gate_i;
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
   import pwmg_pkg::*;
   logic             clk_sys_i = 1'h0, reset_i = 1'h1, ce_i = 1'h1;
   logic             psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
   logic             timer_pwm_source_i = 1'h0, pready_o, up_on, lo_on;
   logic             upper_drive_out_o, lower_drive_out_o;
   logic [7:0]       paddr_i = 8'h0, d;
   logic [31:0]      pwdata_i = 32'h0, prdata_o;
   logic [1:0]       chan_raw_compare_i = 2'h0, cal_compare_i = 2'h0;
   logic [1:0]       oc_irq_o, oc_hyst_en_o, oc_power_en_o;
   logic [1:0]       amp_cancel_mode_o, comp_cancel_mode_o;
   logic [1:0][7:0]  oc_dac_code_o;
   logic [1:0][2:0]  oc_gain_sel_o;
   logic [1:0][3:0]  oc_switch_o;
   logic [1:0]       a_rs, c_rs;
   logic [1:0][5:0]  amp_trim_o;
   logic [1:0][4:0]  comp_trim_o;
   logic [31:0]      exp_q[$];
   int               bad_count = 0, check_count = 0;
   logic [7:0] rst_v [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h10,
                              8'h00, 8'h00, 8'h20, 8'h10, 8'h00, 8'h00};
   logic [3:0] sw_v [4] = '{4'hA, 4'h9, 4'h6, 4'hA};
   logic [7:0] dt_v [7] = '{8'h00, 8'h80, 8'h87, 8'h8F, 8'h90, 8'h9A, 8'hFF};
   int         dn_v [7] = '{1, 2, 9, 17, 5, 25, 65};

   pwmg_top u_dut (.clk_sys_i, .reset_i, .ce_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o(),
      .timer_pwm_source_i, .chan_raw_compare_i, .cal_compare_i,
      .upper_drive_out_o, .lower_drive_out_o, .oc_irq_o, .oc_dac_code_o,
      .oc_gain_sel_o, .oc_hyst_en_o, .oc_switch_o, .oc_power_en_o,
      .amp_cancel_mode_o, .amp_cancel_ref_sel_o(a_rs), .amp_trim_o,
      .comp_cancel_mode_o, .comp_cancel_ref_sel_o(c_rs), .comp_trim_o);
   pwmg_mos_pair u_mos (.upper_gate_i(upper_drive_out_o),
      .lower_gate_i(lower_drive_out_o), .upper_on_o(up_on),
      .lower_on_o(lo_on));

   initial
      forever #5 clk_sys_i = ~clk_sys_i;

   task automatic check(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // One APB transfer; a read leaves its expected value in the queue
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
      if (!w)
         exp_q.push_back({24'h0, v});
      psel_i <= 1'h1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h0, v};
      @(posedge clk_sys_i);
      penable_i <= 1'h1;
      @(posedge clk_sys_i iff pready_o === 1'h1);
      psel_i <= 1'h0;
      penable_i <= 1'h0;
      @(posedge clk_sys_i);
   endtask

   // Count edges from a source rise until the lower pin follows
   task automatic dead(input logic [7:0] dt, input int exp_n);
      int n;
      apb(1'h1, 8'h00, dt);
      repeat (80) @(posedge clk_sys_i);
      timer_pwm_source_i <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk_sys_i);
         #1 n++;
      end while (lower_drive_out_o !== 1'h1 && n < 300);
      check("dead_cycles", n, exp_n);
      if (!dt[7])
         check("wave_upper", upper_drive_out_o, 1'h1);
      @(posedge clk_sys_i);
      timer_pwm_source_i <= 1'h0;
   endtask

   // Raise one channel's trip and check forcing, request and recovery
   task automatic trip(input logic [7:0] m, input int ch,
                       input logic [1:0] pol, input logic s, eu, el);
      int n;
      apb(1'h1, 8'h04, m);
      apb(1'h1, 8'h28, {6'h0, pol});
      timer_pwm_source_i <= s;
      repeat (4) @(posedge clk_sys_i);
      check("upper_idle", upper_drive_out_o, s ^ pol[1]);
      check("lower_idle", lower_drive_out_o, s ^ pol[0]);
      // each channel fed by its own sense input
      chan_raw_compare_i[ch] <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end while (oc_irq_o[ch] !== 1'h1 && n < 40);
      check("irq", n < 40, 1'h1);
      repeat (2) @(posedge clk_sys_i);
      check("upper_trip", upper_drive_out_o, eu);
      check("lower_trip", lower_drive_out_o, el);
      if (pol == 2'h0 && m[1:0] != 2'h0)
         check("mos_on", {up_on, lo_on}, 2'h0);
      apb(1'h0, 8'h08 + 8'(ch * 16), 8'h80);
      chan_raw_compare_i[ch] <= 1'h0;
      repeat (20) @(posedge clk_sys_i);
      check("upper_back", upper_drive_out_o, s ^ pol[1]);
      check("lower_back", lower_drive_out_o, s ^ pol[0]);
   endtask

   // Read data is compared with the oldest outstanding note
   always @(posedge clk_sys_i)
      if (psel_i && penable_i && pready_o === 1'h1 && !pwrite_i)
         check("prdata", prdata_o, exp_q.pop_front());

   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      bad_count++;
      tally_and_finish;
   end

   initial
   begin
      void'($urandom(7335));
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'h0;
      @(posedge clk_sys_i);
      for (int i = 0; i < 12; i++)
         apb(1'h0, 8'(i * 4), rst_v[i]);
      check("trim", {amp_trim_o, comp_trim_o}, 22'h208210);
      apb(1'h1, 8'h00, 8'hFF);
      apb(1'h0, 8'h00, 8'h9F);
      for (int c = 0; c < 2; c++)
      begin
         d = 8'($urandom);
         apb(1'h1, 8'h0C + 8'(c * 16), d);
         check("dac", oc_dac_code_o[c], d);
         apb(1'h0, 8'h0C + 8'(c * 16), d);
      end
      for (int g = 0; g < 8; g++)
      begin
         apb(1'h1, 8'h08, 8'(g * 8 + (g % 2) * 64));
         check("gain", oc_gain_sel_o[0], g > 5 ? 5 : g);
         check("hyst", oc_hyst_en_o[0], g % 2);
      end
      apb(1'h1, 8'h08, 8'h00);
      apb(1'h1, 8'h10, 8'hC0);
      apb(1'h1, 8'h14, 8'h70);
      check("rsel", {a_rs, c_rs}, 4'h5);
      cal_compare_i <= 2'h1;
      for (int m = 0; m < 4; m++)
      begin
         apb(1'h1, 8'h04, 8'(m * 80));
         check("switch", oc_switch_o, {sw_v[m], sw_v[m]});
         check("power", oc_power_en_o, m != 0 ? 3 : 0);
         check("cancel", {amp_cancel_mode_o[0], comp_cancel_mode_o[0]},
               m == 3 ? 3 : 0);
      end
      apb(1'h0, 8'h14, 8'hF0);
      for (int k = 0; k < 7; k++)
         dead(dt_v[k], dn_v[k]);
      apb(1'h1, 8'h00, 8'h00);
      trip(8'h43, 0, 2'h0, 1'h0, 1'h1, 1'h0);
      trip(8'h43, 0, 2'h0, 1'h1, 1'h1, 1'h0);
      trip(8'h1C, 1, 2'h3, 1'h0, 1'h0, 1'h1);
      trip(8'h40, 0, 2'h0, 1'h0, 1'h0, 1'h0);
      // Filter code 3 must hold the level for 8 quarter-rate ticks, 29 to 32 cycles
      apb(1'h1, 8'h08, 8'h03);
      chan_raw_compare_i[0] <= 1'h1;
      d = 8'h00;
      do
      begin
         @(posedge clk_sys_i);
         #1 d++;
      end while (oc_irq_o[0] !== 1'h1 && d < 8'h40);
      check("filter_hold", d >= 8'h1D && d <= 8'h20, 1'h1);
      @(posedge clk_sys_i);
      apb(1'h0, 8'h08, 8'h83);
      chan_raw_compare_i[0] <= 1'h0;
      repeat (40) @(posedge clk_sys_i);
      apb(1'h0, 8'h08, 8'h03);
      // Clock enable low must freeze the lower drive pin and the bus answer
      ce_i <= 1'h0;
      timer_pwm_source_i <= 1'h1;
      repeat (6) @(posedge clk_sys_i);
      check("frozen", {lower_drive_out_o, pready_o}, 2'h0);
      ce_i <= 1'h1;
      repeat (2) @(posedge clk_sys_i);
      check("thawed", lower_drive_out_o, 1'h1);
      tally_and_finish;
   end
endmodule
